// ==== src/hifs_pkg.sv ====
// Package: register map, field layout and constants of the infoframe status bank
package hifs_pkg;
   // ====================================================================
   // Bus geometry
   localparam int unsigned AW = 10;
   localparam int unsigned DW = 32;
   // ====================================================================
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_TOP_LO = 8'h86;
   localparam logic [7:0] IDX_NDF_A = 8'h87;
   localparam logic [7:0] IDX_TOP_HI = 8'h88;
   localparam logic [7:0] IDX_BOT_LO = 8'h89;
   localparam logic [7:0] IDX_BOT_HI = 8'h8A;
   localparam logic [7:0] IDX_LFT_LO = 8'h8B;
   localparam logic [7:0] IDX_LFT_HI = 8'h8C;
   localparam logic [7:0] IDX_RGT_LO = 8'h8D;
   localparam logic [7:0] IDX_RGT_HI = 8'h8E;
   localparam logic [7:0] IDX_NDF_B = 8'h8F;
   localparam logic [7:0] IDX_AUD_VER = 8'h90;
   localparam logic [7:0] IDX_AUD_CODE = 8'h91;
   localparam logic [7:0] IDX_AUD_RATE = 8'h92;
   localparam logic [7:0] IDX_IRQ_STAT = 8'hA0;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hA1;
   // ====================================================================
   // Change flag bit positions
   localparam int unsigned NF = 7;
   localparam int unsigned FLG_AVI = 0;
   localparam int unsigned FLG_AUD = 1;
   localparam int unsigned FLG_SPD = 2;
   localparam int unsigned FLG_MPEG = 3;
   localparam int unsigned FLG_ACP = 4;
   localparam int unsigned FLG_ISRC1 = 5;
   localparam int unsigned FLG_ISRC2 = 6;
   // ====================================================================
   // Packet type codes from the link decoder
   localparam logic [7:0] TYPE_AVI = 8'h82;
   localparam logic [7:0] TYPE_AUD = 8'h84;
   localparam logic [7:0] TYPE_SPD = 8'h83;
   localparam logic [7:0] TYPE_MPEG = 8'h85;
   localparam logic [7:0] TYPE_ACP = 8'h04;
   localparam logic [7:0] TYPE_ISRC1 = 8'h05;
   localparam logic [7:0] TYPE_ISRC2 = 8'h06;
   // ====================================================================
   // Payload layout: byte n of the payload is data byte n+1
   localparam int unsigned PAY_BYTES = 28;
   localparam int unsigned PAY_W = 224;
   localparam int unsigned SIG_W = 16;
   localparam int unsigned PB_TOP = 5;
   localparam int unsigned PB_BOT = 7;
   localparam int unsigned PB_LFT = 9;
   localparam int unsigned PB_RGT = 11;
   localparam int unsigned PB_AUD_CODE = 0;
   localparam int unsigned PB_AUD_RATE = 1;
   localparam logic [7:0] AUD_CODE_MASK = 8'hF7;
   localparam logic [7:0] AUD_RATE_MASK = 8'h1C;
   // ====================================================================
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [NF-1:0] RST_FLAGS = 7'h00;
   localparam logic [SIG_W-1:0] RST_SIG = 16'h0000;
   // ====================================================================
   // Bus handshake states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RESP = 2'b10
   } hifs_state_t;
endpackage

// ==== src/hifs_flag_if.sv ====
// Interface: change events, read clear and flag values between bank and flag unit
`timescale 1ns/10ps
interface hifs_flag_if;
   import hifs_pkg::*;
   logic [NF-1:0] ev;
   logic clr;
   logic [NF-1:0] flags;
   logic [NF-1:0] flags_nx;
   modport owner (input ev, input clr, output flags, output flags_nx);
   modport user (output ev, output clr, input flags, input flags_nx);
endinterface

// ==== src/hifs_flag_unit.sv ====
// Module: sticky change flags, cleared as a whole by a read strobe
`timescale 1ns/10ps
module hifs_flag_unit
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   hifs_flag_if.owner fg
);
   import hifs_pkg::*;

   logic [NF-1:0] flags_q;

   // Set wins over clear so an event in the read cycle survives
   assign fg.flags_nx = (flags_q & ~{NF{fg.clr}}) | fg.ev;
   assign fg.flags = flags_q;

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         flags_q <= RST_FLAGS;
      end
      else
      begin
         flags_q <= fg.flags_nx;
      end
   end

   // ====================================================================
   // Checks
   set_wins_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (fg.ev != RST_FLAGS) |=> ((flags_q & $past(fg.ev)) == $past(fg.ev)))
      else $error("change event lost");
   clear_all_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (fg.clr && fg.ev == RST_FLAGS) |=> (flags_q == RST_FLAGS))
      else $error("flags not cleared by read");
endmodule // hifs_flag_unit

// ==== src/hifs_status_regs.sv ====
// Module: APB status bank for received video and audio infoframe content
`timescale 1ns/10ps
// Notes on behaviour
// - Flag bits 3..6: MPEG source, content protection, ISRC1, ISRC2 packets.
// - Flag bits 0..2: AVI, audio, source product description infoframes.
// - Reading either flag register clears all seven flags; idle value zero.
// - Second flag register mirrors the first with identical seven-bit layout.
// - Top bar end line is 16 bits; zero means no top bar.
// - Top bar end line upper byte sits in its own register.
// - Bottom bar start line as low/high byte pair; beyond lines means none.
// - Left bar last pixel as low/high byte pair; zero means none.
// - Right bar first pixel as low/high pair; beyond width means none.
// - Audio coding type occupies upper nibble of coding register.
// - Coding type codes passed as received: 0 header, 1 PCM, 2..8 compressed.
// - Channel count in low three bits; zero header, n means n+1.
// - Sample rate field in bits four to two; zero means header.
module hifs_status_regs
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [hifs_pkg::AW-1:0] paddr_i,
   input wire logic [hifs_pkg::DW-1:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic pready_o,
   output logic [hifs_pkg::DW-1:0] prdata_o,
   output logic pslverr_o,
   output logic irq_o,
   input wire logic pkt_valid_i,
   input wire logic pkt_ok_i,
   input wire logic [7:0] pkt_type_i,
   input wire logic [7:0] pkt_version_i,
   input wire logic [hifs_pkg::PAY_W-1:0] pkt_payload_i
);
   import hifs_pkg::*;

   // ====================================================================
   // Helpers
   function automatic logic [7:0] pay_byte(input logic [PAY_W-1:0] d,
                                           input int unsigned n);
      pay_byte = d[n*8 +: 8];
   endfunction

   function automatic logic [15:0] pay_word(input logic [PAY_W-1:0] d,
                                            input int unsigned n);
      pay_word = {pay_byte(d, n + 1), pay_byte(d, n)};
   endfunction

   // Folded signature: cheaper than a full payload copy per packet type,
   // at the cost of a rare missed change when two payloads alias
   function automatic logic [SIG_W-1:0] fold_sig(input logic [PAY_W-1:0] d,
                                                 input logic [7:0] ver);
      logic [SIG_W-1:0] acc;
      acc = {8'h00, ver};
      for (int i = 0; i < PAY_BYTES / 2; i++)
      begin
         acc = acc ^ pay_word(d, 2 * i);
      end
      fold_sig = acc;
   endfunction

   function automatic logic [NF-1:0] type_onehot(input logic [7:0] t);
      logic [NF-1:0] oh;
      oh = RST_FLAGS;
      unique case (t)
         TYPE_AVI: oh[FLG_AVI] = 1'b1;
         TYPE_AUD: oh[FLG_AUD] = 1'b1;
         TYPE_SPD: oh[FLG_SPD] = 1'b1;
         TYPE_MPEG: oh[FLG_MPEG] = 1'b1;
         TYPE_ACP: oh[FLG_ACP] = 1'b1;
         TYPE_ISRC1: oh[FLG_ISRC1] = 1'b1;
         TYPE_ISRC2: oh[FLG_ISRC2] = 1'b1;
         default: oh = RST_FLAGS;
      endcase
      type_onehot = oh;
   endfunction

   // ====================================================================
   // Storage
   hifs_state_t state_q;
   logic pready_q;
   logic [DW-1:0] prdata_q;
   logic pslverr_q;
   logic irq_q;
   logic [15:0] top_q;
   logic [15:0] bot_q;
   logic [15:0] lft_q;
   logic [15:0] rgt_q;
   logic [7:0] aud_ver_q;
   logic [7:0] aud_code_q;
   logic [7:0] aud_rate_q;
   logic [SIG_W-1:0] sig_q [NF];
   logic [NF-1:0] seen_q;
   logic [NF-1:0] irq_stat_q;
   logic [NF-1:0] irq_mask_q;

   hifs_flag_if fg ();

   hifs_flag_unit u_flags
   (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .fg(fg.owner)
   );

   // ====================================================================
   // Packet intake
   wire logic pkt_take = pkt_valid_i & pkt_ok_i;
   wire logic [NF-1:0] pkt_sel = type_onehot(pkt_type_i) & {NF{pkt_take}};
   wire logic [SIG_W-1:0] new_sig = fold_sig(pkt_payload_i, pkt_version_i);
   wire logic [NF-1:0] changed;

   for (genvar g = 0; g < NF; g++)
   begin : g_chg
      // First packet after reset always counts as new content
      assign changed[g] = pkt_sel[g] & (~seen_q[g] | (sig_q[g] != new_sig));
   end

   wire logic avi_ld = pkt_sel[FLG_AVI];
   wire logic aud_ld = pkt_sel[FLG_AUD];

   // ====================================================================
   // Bus decode
   wire logic [7:0] idx = paddr_i[9:2];
   wire logic aligned = (paddr_i[1:0] == 2'b00);
   wire logic setup_done = psel_i & penable_i & (state_q == ST_IDLE);
   wire logic finish = (state_q == ST_RESP) & psel_i & penable_i;
   wire logic is_ndf = (idx == IDX_NDF_A) | (idx == IDX_NDF_B);
   wire logic is_bank = (idx >= IDX_TOP_LO) & (idx <= IDX_AUD_RATE);
   wire logic is_irq = (idx == IDX_IRQ_STAT) | (idx == IDX_IRQ_MASK);
   wire logic map_hit = aligned & (is_bank | is_irq);
   wire logic wr_ok = finish & pwrite_i & aligned & pstrb_i[0];
   wire logic wr_stat = wr_ok & (idx == IDX_IRQ_STAT);
   wire logic wr_mask = wr_ok & (idx == IDX_IRQ_MASK);
   wire logic rd_clr = finish & ~pwrite_i & aligned & is_ndf;

   // Flags are read from their next value so nothing set during the
   // wait state escapes both the read data and the clear
   wire logic [7:0] rd_byte =
      (idx == IDX_TOP_LO) ? top_q[7:0] :
      (idx == IDX_NDF_A) ? {1'b0, fg.flags_nx} :
      (idx == IDX_TOP_HI) ? top_q[15:8] :
      (idx == IDX_BOT_LO) ? bot_q[7:0] :
      (idx == IDX_BOT_HI) ? bot_q[15:8] :
      (idx == IDX_LFT_LO) ? lft_q[7:0] :
      (idx == IDX_LFT_HI) ? lft_q[15:8] :
      (idx == IDX_RGT_LO) ? rgt_q[7:0] :
      (idx == IDX_RGT_HI) ? rgt_q[15:8] :
      (idx == IDX_NDF_B) ? {1'b0, fg.flags_nx} :
      (idx == IDX_AUD_VER) ? aud_ver_q :
      (idx == IDX_AUD_CODE) ? aud_code_q :
      (idx == IDX_AUD_RATE) ? aud_rate_q :
      (idx == IDX_IRQ_STAT) ? {1'b0, irq_stat_q} :
      (idx == IDX_IRQ_MASK) ? {1'b0, irq_mask_q} :
      RST_BYTE;

   wire logic [DW-1:0] rd_word = (map_hit & ~pwrite_i) ? {24'h000000, rd_byte} : '0;

   assign fg.ev = changed;
   assign fg.clr = rd_clr;

   // ====================================================================
   // Interrupt
   wire logic [NF-1:0] w1c = wr_stat ? pwdata_i[NF-1:0] : RST_FLAGS;
   wire logic [NF-1:0] stat_d = (irq_stat_q & ~w1c) | changed;
   wire logic [NF-1:0] mask_d = wr_mask ? pwdata_i[NF-1:0] : irq_mask_q;

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         irq_stat_q <= RST_FLAGS;
         irq_mask_q <= RST_FLAGS;
         irq_q <= 1'b0;
      end
      else
      begin
         irq_stat_q <= stat_d;
         irq_mask_q <= mask_d;
         irq_q <= |(stat_d & mask_d);
      end
   end

   // ====================================================================
   // Bus handshake: one wait state, answer registered
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_q <= ST_IDLE;
         pready_q <= 1'b0;
         prdata_q <= '0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
            begin
               if (setup_done)
               begin
                  state_q <= ST_RESP;
                  pready_q <= 1'b1;
                  prdata_q <= rd_word;
                  pslverr_q <= ~map_hit;
               end
            end
            ST_RESP:
            begin
               state_q <= ST_IDLE;
               pready_q <= 1'b0;
               pslverr_q <= 1'b0;
            end
            default:
            begin
               state_q <= ST_IDLE;
               pready_q <= 1'b0;
            end
         endcase
      end
   end

   // ====================================================================
   // Infoframe fields; host writes never reach them
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         top_q <= RST_WORD;
         bot_q <= RST_WORD;
         lft_q <= RST_WORD;
         rgt_q <= RST_WORD;
      end
      else if (avi_ld)
      begin
         top_q <= pay_word(pkt_payload_i, PB_TOP);
         bot_q <= pay_word(pkt_payload_i, PB_BOT);
         lft_q <= pay_word(pkt_payload_i, PB_LFT);
         rgt_q <= pay_word(pkt_payload_i, PB_RGT);
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         aud_ver_q <= RST_BYTE;
         aud_code_q <= RST_BYTE;
         aud_rate_q <= RST_BYTE;
      end
      else if (aud_ld)
      begin
         aud_ver_q <= pkt_version_i;
         // Codes pass through unaltered; bit 3 reserved reads zero
         aud_code_q <= pay_byte(pkt_payload_i, PB_AUD_CODE) & AUD_CODE_MASK;
         aud_rate_q <= pay_byte(pkt_payload_i, PB_AUD_RATE) & AUD_RATE_MASK;
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         seen_q <= RST_FLAGS;
         for (int i = 0; i < NF; i++)
         begin
            sig_q[i] <= RST_SIG;
         end
      end
      else
      begin
         seen_q <= seen_q | pkt_sel;
         for (int i = 0; i < NF; i++)
         begin
            if (pkt_sel[i])
            begin
               sig_q[i] <= new_sig;
            end
         end
      end
   end

   assign pready_o = pready_q;
   assign prdata_o = prdata_q;
   assign pslverr_o = pslverr_q;
   assign irq_o = irq_q;

   // ====================================================================
   // Checks
   mpeg_flag_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (pkt_take && pkt_type_i == TYPE_MPEG && changed[FLG_MPEG]) |=> fg.flags[FLG_MPEG])
      else $error("MPEG change not flagged in bit 3");
   avi_flag_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (pkt_take && pkt_type_i == TYPE_AVI && !seen_q[FLG_AVI]) |=> fg.flags[FLG_AVI])
      else $error("first AVI frame not flagged in bit 0");
   read_clear_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (rd_clr && changed == RST_FLAGS) |=> (fg.flags == RST_FLAGS))
      else $error("flag read did not clear flags");
   mirror_read_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (setup_done && !pwrite_i && aligned && idx == IDX_NDF_B)
      |=> (prdata_q == {25'h0, $past(fg.flags_nx)}))
      else $error("mirror flag register differs");
   top_bar_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      avi_ld |=> (top_q == {$past(pkt_payload_i[55:48]), $past(pkt_payload_i[47:40])}))
      else $error("top bar word wrong");
   bar_pairs_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      avi_ld |=> (bot_q == $past(pkt_payload_i[71:56]) && lft_q == $past(pkt_payload_i[87:72])
                  && rgt_q == $past(pkt_payload_i[103:88])))
      else $error("bar pair wrong");
   audio_code_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      aud_ld |=> (aud_code_q[7:4] == $past(pkt_payload_i[7:4])
                  && aud_code_q[2:0] == $past(pkt_payload_i[2:0])))
      else $error("audio coding field wrong");
   rate_field_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      aud_ld |=> (aud_rate_q == {3'b000, $past(pkt_payload_i[12:10]), 2'b00}))
      else $error("sample rate field wrong");
   same_frame_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (pkt_take && seen_q[FLG_AUD] && pkt_type_i == TYPE_AUD && new_sig == sig_q[FLG_AUD])
      |-> !changed[FLG_AUD])
      else $error("unchanged frame flagged");
   ro_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (finish && pwrite_i && !avi_ld) |=> $stable(top_q) && $stable(rgt_q))
      else $error("host write changed status field");
   irq_level_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      irq_q == |(irq_stat_q & irq_mask_q))
      else $error("interrupt level disagrees with status and mask");
   bad_addr_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (setup_done && !map_hit) |=> (pready_q && pslverr_q && prdata_q == '0))
      else $error("unmapped access not answered with error");
   bad_packet_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (pkt_valid_i && !pkt_ok_i) |-> (changed == RST_FLAGS))
      else $error("bad packet raised a change");
   bad_packet_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      pkt_valid_i && !pkt_ok_i);
   flag_read_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      fg.flags != RST_FLAGS ##1 rd_clr);
   irq_rise_c: cover property (@(posedge clk_sys_i) disable iff (reset_i) $rose(irq_q));
   audio_load_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      aud_ld ##[1:20] (finish && idx == IDX_AUD_CODE));
endmodule // hifs_status_regs

// ==== test/hifs_pkt_source.sv ====
// Source model: presents decoded infoframes to the status bank
`timescale 1ns/10ps
module hifs_pkt_source
(
   input wire logic clk_sys_i,
   output logic pkt_valid_o,
   output logic pkt_ok_o,
   output logic [7:0] pkt_type_o,
   output logic [7:0] pkt_version_o,
   output logic [hifs_pkg::PAY_W-1:0] pkt_payload_o
);
   import hifs_pkg::*;
   initial
   begin
      pkt_valid_o = 1'b0;
      pkt_ok_o = 1'b0;
      pkt_type_o = 8'h00;
      pkt_version_o = 8'h00;
      pkt_payload_o = '0;
   end
   // ====================================================================
   // One packet per call after gap+1 idle cycles
   task automatic send(input logic [7:0] typ, input logic [7:0] ver, input logic ok,
      input logic [PAY_W-1:0] pay, input int gap);
      repeat (gap + 1) @(posedge clk_sys_i);
      pkt_valid_o <= 1'b1;
      pkt_ok_o <= ok;
      pkt_type_o <= typ;
      pkt_version_o <= ver;
      pkt_payload_o <= pay;
      @(posedge clk_sys_i);
      pkt_valid_o <= 1'b0;
      // Released lines scrambled so stale values cannot pass
      pkt_ok_o <= ~ok;
      pkt_type_o <= ~typ;
      pkt_version_o <= ~ver;
      pkt_payload_o <= ~pay;
   endtask
endmodule // hifs_pkt_source

// ==== test/hifs_status_regs_bench.sv ====
// Testbench: APB checks of the infoframe status bank fed by a source model
`timescale 1ns/10ps
module hifs_status_regs_bench;
   import hifs_pkg::*;
   typedef struct packed {logic [DW-1:0] d; logic e;} hifs_exp_t;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [AW-1:0] paddr_i = '0;
   logic [DW-1:0] pwdata_i = '0;
   logic [3:0] pstrb_i = 4'h0;
   logic pready_o;
   logic pslverr_o;
   logic irq_o;
   logic [DW-1:0] prdata_o;
   logic pkt_valid;
   logic pkt_ok;
   logic [7:0] pkt_type;
   logic [7:0] pkt_ver;
   logic [PAY_W-1:0] pkt_pay;
   hifs_exp_t exp_q[$];
   int n_mismatch = 0;
   int tests_run = 0;
   logic [31:0] lfsr_q = 32'hC024;
   logic [PAY_W-1:0] pay;
   logic [7:0] ver;
   logic [7:0] kinds[NF] = '{TYPE_AVI, TYPE_AUD, TYPE_SPD, TYPE_MPEG, TYPE_ACP,
      TYPE_ISRC1, TYPE_ISRC2};

   always #5 clk_sys_i = ~clk_sys_i;

   hifs_status_regs dut
   (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
      .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
      .pkt_valid_i(pkt_valid), .pkt_ok_i(pkt_ok), .pkt_type_i(pkt_type),
      .pkt_version_i(pkt_ver), .pkt_payload_i(pkt_pay)
   );
   hifs_pkt_source src
   (
      .clk_sys_i(clk_sys_i), .pkt_valid_o(pkt_valid), .pkt_ok_o(pkt_ok),
      .pkt_type_o(pkt_type), .pkt_version_o(pkt_ver), .pkt_payload_o(pkt_pay)
   );

   // ====================================================================
   // Helpers
   function automatic logic [PAY_W-1:0] rnd_pay();
      logic [PAY_W-1:0] p;
      for (int i = 0; i < PAY_W / 32; i++)
      begin
         lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
         p[i*32 +: 32] = lfsr_q;
      end
      return p;
   endfunction

   task automatic chk_data(input hifs_exp_t e, input hifs_exp_t g);
      tests_run++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("Error at %0t: expected %0h got %0h", $time, e, g);
      end
   endtask

   task automatic chk_irq(input logic e);
      tests_run++;
      if (irq_o !== e)
      begin
         n_mismatch++;
         $display("Error at %0t: irq expected %0h got %0h", $time, e, irq_o);
      end
   endtask

   task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] wd,
      input logic [DW-1:0] ed, input logic ee);
      exp_q.push_back({ed, ee});
      @(posedge clk_sys_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      pstrb_i <= 4'hF;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      // Only the watchdog ends a wait that never completes
      do
      begin
         @(posedge clk_sys_i);
      end
      while (pready_o !== 1'b1);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      apb(1'b0, {idx, 2'b00}, '0, {24'h0, e}, 1'b0);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, {idx, 2'b00}, {24'h0, d}, '0, 1'b0);
   endtask

   task automatic print_verdict();
      if (exp_q.size() != 0)
         n_mismatch++;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ====================================================================
   // Result monitor: oldest note against each completion
   always @(posedge clk_sys_i)
      if (pready_o === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk_data('1, {prdata_o, pslverr_o});
         else
            chk_data(exp_q.pop_front(), {prdata_o, pslverr_o});
      end

   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      n_mismatch++;
      print_verdict();
   end

   // ====================================================================
   // Main sequence
   initial
   begin
      repeat (4) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      chk_irq(1'b0);
      rd(IDX_NDF_A, 8'h00);
      wr(IDX_IRQ_MASK, 8'h7F);
      rd(IDX_IRQ_MASK, 8'h7F);
      for (int i = 0; i < NF; i++)
      begin
         src.send(kinds[i], 8'h01, 1'b1, rnd_pay(), i % 3);
         rd(i[0] ? IDX_NDF_B : IDX_NDF_A, 8'(1 << i));
         rd(IDX_NDF_B, 8'h00);
      end
      chk_irq(1'b1);
      rd(IDX_IRQ_STAT, 8'h7F);
      wr(IDX_IRQ_STAT, 8'h01);
      rd(IDX_IRQ_STAT, 8'h7E);
      wr(IDX_IRQ_STAT, 8'h7E);
      repeat (2) @(posedge clk_sys_i);
      chk_irq(1'b0);
      pay = rnd_pay();
      src.send(TYPE_AVI, 8'h02, 1'b1, pay, 0);
      rd(IDX_TOP_LO, pay[8*PB_TOP +: 8]);
      rd(IDX_TOP_HI, pay[8*PB_TOP+8 +: 8]);
      rd(IDX_BOT_LO, pay[8*PB_BOT +: 8]);
      rd(IDX_BOT_HI, pay[8*PB_BOT+8 +: 8]);
      rd(IDX_LFT_LO, pay[8*PB_LFT +: 8]);
      rd(IDX_LFT_HI, pay[8*PB_LFT+8 +: 8]);
      rd(IDX_RGT_LO, pay[8*PB_RGT +: 8]);
      rd(IDX_RGT_HI, pay[8*PB_RGT+8 +: 8]);
      wr(IDX_TOP_HI, 8'hFF);
      rd(IDX_TOP_HI, pay[8*PB_TOP+8 +: 8]);
      rd(IDX_NDF_B, 8'h01);
      // Identical content, a bad checksum and an unknown type leave all untouched
      src.send(TYPE_AVI, 8'h02, 1'b1, pay, 2);
      src.send(TYPE_AVI, 8'h02, 1'b0, rnd_pay(), 1);
      src.send(8'h81, 8'h02, 1'b1, rnd_pay(), 0);
      rd(IDX_NDF_A, 8'h00);
      rd(IDX_TOP_LO, pay[8*PB_TOP +: 8]);
      wr(IDX_IRQ_STAT, 8'h7F);
      wr(IDX_IRQ_MASK, 8'h00);
      for (int c = 0; c <= 8; c++)
      begin
         pay = rnd_pay();
         pay[7:4] = c[3:0];
         ver = lfsr_q[7:0];
         src.send(TYPE_AUD, ver, 1'b1, pay, c % 2);
         rd(IDX_AUD_CODE, {pay[7:4], 1'b0, pay[2:0]});
         rd(IDX_AUD_RATE, {3'b000, pay[12:10], 2'b00});
         rd(IDX_AUD_VER, ver);
      end
      chk_irq(1'b0);
      rd(IDX_IRQ_STAT, 8'h02);
      apb(1'b0, 10'h3FC, '0, '0, 1'b1);
      apb(1'b0, 10'h21D, '0, '0, 1'b1);
      apb(1'b1, 10'h3F0, 32'h0000007F, '0, 1'b1);
      repeat (3) @(posedge clk_sys_i);
      print_verdict();
   end
endmodule // hifs_status_regs_bench
